// File: bench/iaa_chk.sv
// port checker for the adder execution block
`timescale 1ns/10ps
module iaa_chk #(
  parameter ADDR_W = 12
) (
  // clock, reset and enable
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // data memory
  input wire logic [15:0] dmem_addr_q,
  input wire logic [7:0] dmem_wdata_q,
  input wire logic dmem_we
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // cycles with ce high since the last instruction was taken
  logic [7:0] cnt_q;
  wire take = psel & penable & pwrite & ce & (paddr == 12'h000);
  wire setup = psel & !penable & ce;
  wire unm = paddr >= 12'h100 || (paddr >= 12'h014 && paddr < 12'h040)
    || (paddr >= 12'h050 && paddr < 12'h080);
  always @(posedge clock or posedge rst) begin
    if (rst) cnt_q <= 8'h00;
    else if (take) cnt_q <= 8'h00;
    else if (ce && cnt_q != 8'hFF) cnt_q <= cnt_q + 8'h01;
  end
  property p_we1; dmem_we |=> !dmem_we; endproperty
  property p_ast; dmem_we |-> $stable(dmem_addr_q); endproperty
  property p_wst; dmem_we |-> $stable(dmem_wdata_q); endproperty
  // three T-states plus up to three wait states
  property p_wt; dmem_we |-> cnt_q >= 8'h02 && cnt_q <= 8'h05; endproperty
  property p_ce; dmem_we |-> ce; endproperty
  property p_unm; setup && unm |=> pslverr && prdata == 32'h0; endproperty
  property p_st; setup && paddr == 12'h004 |=> !pslverr; endproperty
  property p_hold; psel && penable && ce |=> $stable(prdata); endproperty
  a_we1: assert property (p_we1)
    else $error("store pulse too long");
  a_ast: assert property (p_ast)
    else $error("store address moved");
  a_wst: assert property (p_wst)
    else $error("store data moved");
  a_wt: assert property (p_wt)
    else $error("store at wrong time");
  a_ce: assert property (p_ce)
    else $error("store while frozen");
  a_unm: assert property (p_unm)
    else $error("bad address taken");
  a_st: assert property (p_st)
    else $error("status refused");
  a_hold: assert property (p_hold)
    else $error("read data moved");
  c_take: cover property (take);
  c_we: cover property (dmem_we);
  c_err: cover property (psel && penable && pslverr);
endmodule // iaa_chk

bind iaa_top iaa_chk #(.ADDR_W(ADDR_W)) u_iaa_chk (.clock(clock), .rst(rst),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .dmem_addr_q(dmem_addr_q), .dmem_wdata_q(dmem_wdata_q),
  .dmem_we(dmem_we));

// File: bench/tb.sv
// self-checking bench for the adder execution block
`timescale 1ns/10ps
module tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  wire pready, pslverr, dmem_we;
  wire [31:0] prdata;
  wire [15:0] dmem_addr_q;
  wire [7:0] dmem_wdata_q;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  int k;
  logic [32:0] q_exp[$], q_msk[$];
  logic [23:0] q_mem[$];
  logic [7:0] a, b, v;
  logic [4:0] r;
  logic [15:0] p;
  iaa_top u_iaa_top (.clock(clock), .rst(rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .dmem_addr_q(dmem_addr_q), .dmem_wdata_q(dmem_wdata_q),
    .dmem_we(dmem_we));
  initial forever #4 clock = ~clock;
  task conclude;
    $display("mismatches %0d checks %0d", n_mismatch, n_checks);
    if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task cmp_rd(input logic [32:0] g);
    logic [32:0] x, m;
    x = q_exp.pop_front();
    m = q_msk.pop_front();
    n_checks++;
    if ((g & m) !== (x & m)) begin
      n_mismatch++;
      $display("[ERR] %0t read %h exp %h", $time, g, x);
    end
  endtask
  task cmp_mem(input logic [23:0] g);
    logic [23:0] x;
    x = q_mem.size() ? q_mem.pop_front() : 24'hx;
    n_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("[ERR] %0t store %h exp %h", $time, g, x);
    end
  endtask
  // *******
  // apb master, one transfer then one idle cycle
  // *******
  task apb(input logic [11:0] ad, input logic [31:0] d, input logic w);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= ad;
    pwdata <= d;
    pwrite <= w;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task rd(input logic [11:0] ad, input logic [32:0] x, m);
    q_exp.push_back(x);
    q_msk.push_back(m);
    apb(ad, 32'h0, 1'b0);
  endtask
  // issue, freeze three cycles, then busy must still show in the last
  // t-state; a block that ignores the freeze has gone idle by then
  task ex(input logic [15:0] i, input int t);
    apb(12'h000, {16'h0, i}, 1'b1);
    ce <= 1'b0;
    repeat (3) @(posedge clock);
    ce <= 1'b1;
    repeat (t - 2) @(posedge clock);
    rd(12'h004, 33'h1, 33'h1);
  endtask
  function logic [11:0] ra(input logic [4:0] i);
    ra = {5'h0, i, 2'b00} | 12'h080;
  endfunction
  function logic [7:0] fl(input logic [7:0] x, y);
    logic [8:0] s;
    s = {1'b0, x} + {1'b0, y};
    fl = {s[7], s[7:0] == 8'h00, s[8], x[7] == y[7] && s[7] != x[7], 4'h0};
  endfunction
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc > 5000) begin
      n_mismatch++;
      $display("[ERR] %0t timeout", $time);
      conclude;
    end
    if (psel && penable && !pwrite && pready === 1'b1)
      cmp_rd({pslverr, prdata});
    if (dmem_we === 1'b1)
      cmp_mem({dmem_addr_q, dmem_wdata_q});
  end
  initial begin
    void'($urandom(82));
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(12'h004, 33'h0, '1);
    rd(12'h008, 33'h0, '1);
    for (k = 0; k < 8; k++) begin
      r = 5'($urandom_range(15, 0));
      a = 8'($urandom);
      v = 8'($urandom);
      b = k == 0 ? 8'hFF : k == 1 ? 8'h80 : k == 2 ? 8'h7F : 8'($urandom);
      apb(ra(r), {24'h0, a}, 1'b1);
      apb(ra(r ^ 5'h10), {24'h0, v}, 1'b1);
      ex({4'h0, b, r[3:0]}, 2);
      rd(ra(r), {25'h0, a + b}, 33'hFF);
      rd(12'h004, {25'h0, fl(a, b)}, 33'hFF);
      rd(ra(r ^ 5'h10), {25'h0, v}, 33'hFF);
    end
    // both accumulators, all wait-state settings
    for (k = 0; k < 4; k++) begin
      a = 8'($urandom);
      b = 8'($urandom);
      v = 8'($urandom);
      r = 5'h10 | 5'(k);
      apb(12'h008, {29'h0, k[1:0], k[0]}, 1'b1);
      apb(12'h00C, {24'h0, a}, 1'b1);
      apb(12'h010, {24'h0, b}, 1'b1);
      apb(ra(r), {24'h0, v}, 1'b1);
      ex({4'h1, 1'b0, r, 1'b0, r ^ 5'h1F}, 2 + k);
      rd(ra(r ^ 5'h1F), {25'h0, v + (k[0] ? b : a)}, 33'hFF);
    end
    apb(12'h008, 32'h2, 1'b1);
    for (k = 0; k < 4; k++) begin
      p = k == 2 ? 16'hFFFF : 16'($urandom);
      a = 8'($urandom);
      v = 8'($urandom);
      r = 5'($urandom);
      apb(12'h040 | {8'h0, k[1:0], 2'b00}, {16'h0, p}, 1'b1);
      apb(12'h00C, {24'h0, a}, 1'b1);
      apb(ra(r), {24'h0, v}, 1'b1);
      q_mem.push_back({k == 3 ? p + 16'h1 : p, v + a});
      ex({4'h1, 1'b1, r, k[1:0], 2'b00, k[1:0]}, 4);
      rd(12'h040 | {8'h0, k[1:0], 2'b00}, {17'h0, k == 0 ? p - 16'h1 :
        k == 1 ? p : p + 16'h1}, 33'hFFFF);
    end
    rd(12'h020, {1'b1, 32'h0}, '1);
    apb(12'h000, 32'h0000F000, 1'b1);
    rd(12'h004, 33'h2, 33'h2);
    apb(12'h004, 32'h2, 1'b1);
    rd(12'h004, 33'h0, 33'h2);
    // reset in mid-run clears the register file and the configuration
    apb(ra(5'h05), 32'hA5, 1'b1);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(ra(5'h05), 33'h0, 33'hFF);
    rd(12'h008, 33'h0, '1);
    repeat (4) @(posedge clock);
    // an expected store that never came is a failure too
    if (q_mem.size() != 0) begin
      n_mismatch++;
      $display("[ERR] %0t store missing", $time);
    end
    conclude;
  end
endmodule // tb

// File: design/iaa_adder.v
// eight bit adder with negative, zero, carry and overflow flags
`timescale 1ns/10ps
module iaa_adder #(
  parameter W = 8
) (
  // operands
  input wire [W-1:0] opa,
  input wire [W-1:0] opb,
  // result
  output wire [W-1:0] sum,
  output wire [3:0] flags
);
  wire [W:0] full;
  wire neg;
  wire zero;
  wire ovf;

  // unsigned and two's complement operands share one adder
  assign full = {1'b0, opa} + {1'b0, opb};
  assign sum = full[W-1:0];
  assign neg = full[W-1];
  assign zero = (full[W-1:0] == {W{1'b0}});
  assign ovf = (opa[W-1] == opb[W-1]) && (full[W-1] != opa[W-1]);
  // flag order n z c v
  assign flags = {neg, zero, full[W], ovf};
endmodule // iaa_adder

// File: design/iaa_defs.vh
// constants for the immediate and accumulator adder execution block
`ifndef IAA_DEFS_VH
`define IAA_DEFS_VH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define IAA_OFF_INSTR 12'h000
`define IAA_OFF_STATUS 12'h004
`define IAA_OFF_CONFIG 12'h008
`define IAA_OFF_ACC_MAIN 12'h00C
`define IAA_OFF_ACC_ALT 12'h010
`define IAA_OFF_PTR_BASE 12'h040
`define IAA_OFF_REG_BASE 12'h080

// ****************************************
// instruction fields
// ****************************************
`define IAA_OPC_MSB 15
`define IAA_OPC_LSB 12
`define IAA_OPC_ADD 4'h0
`define IAA_OPC_ACCUMULATOR_SUM_OP 4'h1
`define IAA_IMM_MSB 11
`define IAA_IMM_LSB 4
`define IAA_LREG_MSB 3
`define IAA_LREG_LSB 0
`define IAA_IDX_BIT 11
`define IAA_SRC_MSB 10
`define IAA_SRC_LSB 6
`define IAA_DST_MSB 4
`define IAA_DST_LSB 0
`define IAA_MODE_MSB 5
`define IAA_MODE_LSB 4
`define IAA_PTR_MSB 1
`define IAA_PTR_LSB 0

// index modes
`define IAA_MODE_POSTDEC 2'h0
`define IAA_MODE_NOCHG 2'h1
`define IAA_MODE_POSTINC 2'h2
`define IAA_MODE_PREINC 2'h3

// ****************************************
// status and config fields
// ****************************************
`define IAA_ST_BUSY 0
`define IAA_ST_ILLEGAL 1
`define IAA_ST_FLAG_LSB 4
`define IAA_CFG_BANK 0
`define IAA_CFG_WAIT_LSB 1

// ****************************************
// reset values and timing
// ****************************************
`define IAA_RST_BYTE 8'h00
`define IAA_RST_PTR 16'h0000
`define IAA_RST_FLAGS 4'h0
`define IAA_T_ADD 4'h2
`define IAA_T_ACCUMULATOR_SUM_OP_REG 4'h2
`define IAA_T_ACCUMULATOR_SUM_OP_MEM 4'h3

`endif

// File: design/iaa_top.v
// execution logic for the immediate-sum and accumulator-sum instructions
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/10ps
`include "iaa_defs.vh"
module iaa_top #(
  parameter ADDR_W = 12,
  parameter NREG = 32,
  parameter NPTR = 4
) (
  // clock, reset, enable
  input wire clock,
  input wire rst,
  input wire ce,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  // data memory write port
  output reg [15:0] dmem_addr_q,
  output reg [7:0] dmem_wdata_q,
  output wire dmem_we
);
  // ****************************************
  // states and decode helpers
  // ****************************************
  localparam ST_IDLE = 2'b01;
  localparam ST_RUN = 2'b10;

  function is_add;
    input [15:0] ins;
    begin
      is_add = (ins[`IAA_OPC_MSB:`IAA_OPC_LSB] == `IAA_OPC_ADD);
    end
  endfunction

  function is_accumulator_sum_op;
    input [15:0] ins;
    begin
      is_accumulator_sum_op = (ins[`IAA_OPC_MSB:`IAA_OPC_LSB] == `IAA_OPC_ACCUMULATOR_SUM_OP);
    end
  endfunction

  // ****************************************
  // storage
  // ****************************************
  reg [7:0] regs_q [0:NREG-1];
  reg [15:0] ptr_q [0:NPTR-1];
  reg [7:0] acc_main_q;
  reg [7:0] acc_alt_q;
  reg bank_q;
  reg [1:0] wait_q;
  reg [3:0] flags_q;
  reg illegal_q;
  reg [15:0] instr_q;
  reg [1:0] state_q;
  reg [3:0] cnt_q;
  reg [7:0] result_q;
  reg [3:0] res_flags_q;

  // ****************************************
  // apb decode
  // ****************************************
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire wr = access && pwrite;
  wire busy = (state_q == ST_RUN);
  wire [ADDR_W-1:0] off = {paddr[ADDR_W-1:2], 2'b00};
  wire hit_instr = (off == `IAA_OFF_INSTR);
  wire hit_status = (off == `IAA_OFF_STATUS);
  wire hit_config = (off == `IAA_OFF_CONFIG);
  wire hit_accm = (off == `IAA_OFF_ACC_MAIN);
  wire hit_acca = (off == `IAA_OFF_ACC_ALT);
  wire hit_ptr = ({off[ADDR_W-1:4], 4'h0} == `IAA_OFF_PTR_BASE);
  wire hit_reg = ({off[ADDR_W-1:7], 7'h00} == `IAA_OFF_REG_BASE);
  wire [1:0] ptr_sel = paddr[3:2];
  wire [4:0] reg_sel = paddr[6:2];
  wire mapped = hit_instr || hit_status || hit_config || hit_accm ||
                hit_acca || hit_ptr || hit_reg;
  // state that the running instruction reads or writes is locked while busy
  wire locked = hit_instr || hit_config || hit_accm || hit_acca ||
                hit_ptr || hit_reg;
  wire err_now = !mapped || (pwrite && busy && locked);
  // the verdict taken in the setup cycle decides the access, so the
  // reported error and the effect agree, except that a write with ce low in the access cycle is dropped without an error
  wire wr_ok = wr && ce && !pslverr;

  assign pready = 1'b1;

  // ****************************************
  // instruction issue and operands
  // ****************************************
  wire [15:0] new_ins = pwdata[15:0];
  wire issue = wr_ok && hit_instr;
  wire ins_add = is_add(new_ins);
  wire ins_accumulator_sum_op = is_accumulator_sum_op(new_ins);
  wire ins_idx = new_ins[`IAA_IDX_BIT];
  // only the low four register bits exist for the immediate form
  wire [4:0] lreg;
  assign lreg = {1'b0, new_ins[`IAA_LREG_MSB:`IAA_LREG_LSB]};
  wire [4:0] src = new_ins[`IAA_SRC_MSB:`IAA_SRC_LSB];
  wire [7:0] imm = new_ins[`IAA_IMM_MSB:`IAA_IMM_LSB];
  wire [7:0] acc_act = bank_q ? acc_alt_q : acc_main_q;
  wire [7:0] op_a = ins_add ? regs_q[lreg] : regs_q[src];
  wire [7:0] op_b = ins_add ? imm : acc_act;
  wire [7:0] sum;
  wire [3:0] sum_flags;

  iaa_adder #(
    .W(8)
  ) u_adder (
    .opa(op_a),
    .opb(op_b),
    .sum(sum),
    .flags(sum_flags)
  );

  // t-state count of the new instruction plus wait states
  wire [3:0] t_base = ins_add ? `IAA_T_ADD :
                      ins_idx ? `IAA_T_ACCUMULATOR_SUM_OP_MEM :
                      `IAA_T_ACCUMULATOR_SUM_OP_REG;
  wire [3:0] t_total = t_base + {2'b00, wait_q};

  // ****************************************
  // sequencer
  // ****************************************
  wire last = busy && (cnt_q == 4'h0);
  wire run_add = is_add(instr_q);
  wire run_idx = is_accumulator_sum_op(instr_q) && instr_q[`IAA_IDX_BIT];
  wire [1:0] run_mode = instr_q[`IAA_MODE_MSB:`IAA_MODE_LSB];
  wire [1:0] run_ptr = instr_q[`IAA_PTR_MSB:`IAA_PTR_LSB];
  wire [4:0] run_dst = run_add ?
    {1'b0, instr_q[`IAA_LREG_MSB:`IAA_LREG_LSB]} :
    instr_q[`IAA_DST_MSB:`IAA_DST_LSB];
  wire commit_reg = last && !run_idx;
  wire [15:0] cur_ptr = ptr_q[new_ins[`IAA_PTR_MSB:`IAA_PTR_LSB]];
  wire [1:0] new_mode = new_ins[`IAA_MODE_MSB:`IAA_MODE_LSB];

  // memory write strobe sits in the final t-state
  assign dmem_we = last && run_idx && ce;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      instr_q <= 16'h0000;
      result_q <= `IAA_RST_BYTE;
      res_flags_q <= `IAA_RST_FLAGS;
      dmem_addr_q <= `IAA_RST_PTR;
      dmem_wdata_q <= `IAA_RST_BYTE;
    end else if (ce) begin
      case (state_q)
        ST_IDLE: begin
          if (issue && (ins_add || ins_accumulator_sum_op)) begin
            state_q <= ST_RUN;
            cnt_q <= t_total - 4'h1;
            instr_q <= new_ins;
            result_q <= sum;
            res_flags_q <= sum_flags;
            dmem_wdata_q <= sum;
            // pre-increment addresses the advanced pointer
            if (new_mode == `IAA_MODE_PREINC) begin
              dmem_addr_q <= cur_ptr + 16'h0001;
            end else begin
              dmem_addr_q <= cur_ptr;
            end
          end
        end
        ST_RUN: begin
          if (cnt_q == 4'h0) begin
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // flags, control and status
  // ****************************************
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      flags_q <= `IAA_RST_FLAGS;
      illegal_q <= 1'b0;
      bank_q <= 1'b0;
      wait_q <= 2'b00;
      acc_main_q <= `IAA_RST_BYTE;
      acc_alt_q <= `IAA_RST_BYTE;
    end else if (ce) begin
      if (last) begin
        flags_q <= res_flags_q;
      end
      // a new illegal issue wins over a clear in the same cycle
      if (issue && !ins_add && !ins_accumulator_sum_op) begin
        illegal_q <= 1'b1;
      end else if (wr_ok && hit_status && pwdata[`IAA_ST_ILLEGAL]) begin
        illegal_q <= 1'b0;
      end
      if (wr_ok && hit_config) begin
        bank_q <= pwdata[`IAA_CFG_BANK];
        wait_q <= pwdata[`IAA_CFG_WAIT_LSB+1:`IAA_CFG_WAIT_LSB];
      end
      if (wr_ok && hit_accm) begin
        acc_main_q <= pwdata[7:0];
      end
      if (wr_ok && hit_acca) begin
        acc_alt_q <= pwdata[7:0];
      end
    end
  end

  // ****************************************
  // register file and index pointers
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi = gi + 1) begin : g_reg
      always @(posedge clock or posedge rst) begin
        if (rst) begin
          regs_q[gi] <= `IAA_RST_BYTE;
        end else if (ce) begin
          if (commit_reg && (run_dst == gi)) begin
            regs_q[gi] <= result_q;
          end else if (wr_ok && hit_reg && (reg_sel == gi)) begin
            regs_q[gi] <= pwdata[7:0];
          end
        end
      end
    end
    for (gi = 0; gi < NPTR; gi = gi + 1) begin : g_ptr
      always @(posedge clock or posedge rst) begin
        if (rst) begin
          ptr_q[gi] <= `IAA_RST_PTR;
        end else if (ce) begin
          if (last && run_idx && (run_ptr == gi)) begin
            case (run_mode)
              `IAA_MODE_POSTDEC: begin
                ptr_q[gi] <= ptr_q[gi] - 16'h0001;
              end
              `IAA_MODE_POSTINC: begin
                ptr_q[gi] <= ptr_q[gi] + 16'h0001;
              end
              `IAA_MODE_PREINC: begin
                ptr_q[gi] <= ptr_q[gi] + 16'h0001;
              end
              default: begin
                ptr_q[gi] <= ptr_q[gi];
              end
            endcase
          end else if (wr_ok && hit_ptr && (ptr_sel == gi)) begin
            ptr_q[gi] <= pwdata[15:0];
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // read data, captured in the setup cycle
  // ****************************************
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h00000000;
    if (hit_instr) begin
      rd_mux = {16'h0000, instr_q};
    end else if (hit_status) begin
      rd_mux = {24'h000000, flags_q, 2'b00, illegal_q, busy};
    end else if (hit_config) begin
      rd_mux = {29'h00000000, wait_q, bank_q};
    end else if (hit_accm) begin
      rd_mux = {24'h000000, acc_main_q};
    end else if (hit_acca) begin
      rd_mux = {24'h000000, acc_alt_q};
    end else if (hit_ptr) begin
      rd_mux = {16'h0000, ptr_q[ptr_sel]};
    end else if (hit_reg) begin
      rd_mux = {24'h000000, regs_q[reg_sel]};
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (ce) begin
      if (setup) begin
        prdata <= pwrite ? 32'h00000000 : rd_mux;
        pslverr <= err_now;
      end
    end
  end
endmodule // iaa_top
